/* File: rtl/mute_pkg.sv */
// constants for the two-signal T muting controller
// assumes a 100 MHz core clock and a plain one-cycle register port
`default_nettype none
package mute_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ     = 100_000_000;
	localparam int unsigned MS_PER_S   = 1000;
	localparam int unsigned MS_PER_MIN = 60000;
	localparam int unsigned MS_CYCLES  = CLK_HZ / MS_PER_S;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_GAP_MIN  = 8'h04;
	localparam logic [7:0] OFS_GAP_MAX  = 8'h08;
	localparam logic [7:0] OFS_HOLD     = 8'h0c;
	localparam logic [7:0] OFS_TIMEOUT  = 8'h10;
	localparam logic [7:0] OFS_DEACT    = 8'h14;
	localparam logic [7:0] OFS_ACT      = 8'h18;
	localparam logic [7:0] OFS_TEACH    = 8'h1c;
	localparam logic [7:0] OFS_BEAM_TOL = 8'h20;
	localparam logic [7:0] OFS_OVR_TMO  = 8'h24;
	localparam logic [7:0] OFS_STATUS   = 8'h28;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int unsigned CTRL_DYN      = 0;
	localparam int unsigned CTRL_TOP      = 1;
	localparam int unsigned CTRL_LAMP     = 2;
	localparam int unsigned CTRL_OVR_EDGE = 3;
	localparam int unsigned CTRL_OVR_MAN  = 4;
	localparam int unsigned CTRL_INFINITE = 5;
	localparam int unsigned CTRL_W        = 6;
	// ------------------------------------------------------------
	// ranges and reset values
	// ------------------------------------------------------------
	localparam logic [5:0]  RST_CTRL     = 6'h00;
	localparam logic [9:0]  GAP_MIN_LO   = 10'h00a;
	localparam logic [9:0]  RST_GAP_MIN  = 10'h064;
	localparam logic [4:0]  GAP_MAX_LO   = 5'h01;
	localparam logic [4:0]  GAP_MAX_HI   = 5'h10;
	localparam logic [4:0]  RST_GAP_MAX  = 5'h04;
	localparam logic [9:0]  MS_HI        = 10'h3e8;
	localparam logic [15:0] TMO_LO       = 16'h000a;
	localparam logic [15:0] TMO_HI       = 16'he100;
	localparam logic [15:0] RST_TIMEOUT  = 16'h0258;
	localparam logic [11:0] TEACH_LO     = 12'h1f4;
	localparam logic [11:0] TEACH_HI     = 12'hfa0;
	localparam logic [11:0] RST_TEACH    = 12'h7d0;
	localparam logic [2:0]  TOL_HI       = 3'h6;
	localparam logic [8:0]  OVR_LO       = 9'h001;
	localparam logic [8:0]  OVR_HI       = 9'h100;
	localparam logic [8:0]  RST_OVR_TMO  = 9'h002;
	// ------------------------------------------------------------
	// interrupt events
	// ------------------------------------------------------------
	localparam int unsigned EV_START   = 0;
	localparam int unsigned EV_END     = 1;
	localparam int unsigned EV_GAP     = 2;
	localparam int unsigned EV_TIMEOUT = 3;
	localparam int unsigned EV_LAMP    = 4;
	localparam int unsigned EV_HEIGHT  = 5;
	localparam int unsigned EV_OVR_END = 6;
	localparam int unsigned EV_W       = 7;

	typedef enum logic [2:0] {
		ST_IDLE, ST_GAP, ST_MUTE, ST_HOLD, ST_BLOCK, ST_OVR, ST_LOCK
	} mute_state_t;
endpackage : mute_pkg
`default_nettype wire

/* File: rtl/ms_tick.sv */
// millisecond strobe from the core clock
// assumes the divide count fits in 32 bits
`default_nettype none
module ms_tick #(
	parameter int unsigned DIV = 100000
) (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	logic [31:0] cnt_q;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b0;
		end
		else if (cnt_q == DIV - 1)
		begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule : ms_tick
`default_nettype wire

/* File: rtl/mute_filter.sv */
// activation and deactivation filter of one muting input
// assumes tick_i is a one-cycle millisecond strobe
`default_nettype none
module mute_filter (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       tick_i,
	input  wire logic       raw_i,
	input  wire logic [9:0] act_ms_i,
	input  wire logic [9:0] deact_ms_i,
	output logic            level_o
);
	logic [9:0] cnt_q;
	logic [9:0] lim;

	assign lim = level_o ? deact_ms_i : act_ms_i;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q   <= 10'h0;
			level_o <= 1'b0;
		end
		else if (raw_i == level_o)
			cnt_q <= 10'h0;
		else if (cnt_q >= lim)
		begin
			cnt_q   <= 10'h0;
			level_o <= raw_i;
		end
		else if (tick_i)
			cnt_q <= cnt_q + 10'h1;
	end
endmodule : mute_filter
`default_nettype wire

/* File: rtl/t_mute_ctrl.sv */
// two-signal bidirectional T muting controller with override
// assumes synchronous inputs and a one-cycle register port
//
// Decided for this implementation: the address-and-strobe port and the address map.
`default_nettype none
// Overview of operation
// - mute once both inputs active, any order, gap within maximum
// - end muting when either input drops, or after hold time
// - hold time 0 to 1000 ms, default 0
// - gap below minimum or above maximum refuses muting
// - minimum gap 10 to 1000 ms, default 100 ms
// - maximum gap 1 to 16 s, default 4 s
// - deactivation filter 0 to 1000 ms, default 0
// - activation filter 0 to 1000 ms, default 0
// - dynamic muting limits height to tallest seen during teach time
// - zero to six extra beams tolerated over taught height
// - start-from-top option reverses beam order
// - optional lamp check requires external lamp present
// - edge override continues after override input released
// - automatic override restart lets outputs follow curtain, keeps monitoring
// - manual override restart enters interlock until restart
// - muting requests accepted only while curtain is on
module t_mute_ctrl
	import mute_pkg::*;
#(
	parameter int unsigned MS_DIV = mute_pkg::MS_CYCLES,
	parameter int unsigned BEAMS  = 16
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic [7:0]       addr_i,
	input  wire logic [31:0]      wr_data_i,
	input  wire logic             wr_en_i,
	input  wire logic             rd_en_i,
	output logic      [31:0]      rd_data_o,
	input  wire logic             mute_input_a_i,
	input  wire logic             mute_input_b_i,
	input  wire logic             curtain_on_i,
	input  wire logic [BEAMS-1:0] beams_i,
	input  wire logic             lamp_ok_i,
	input  wire logic             override_i,
	input  wire logic             restart_i,
	output logic                  mute_active_o,
	output logic                  override_active_o,
	output logic                  interlock_o,
	output logic                  safety_out_o,
	output logic                  irq_o
);
	import mute_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	function automatic logic [5:0] height(input logic [BEAMS-1:0] b,
		input logic top);
		logic [5:0] h;
		h = 6'h0;
		for (int i = 0; i < BEAMS; i++)
		begin
			if (top && b[BEAMS-1-i])
				h = 6'(i + 1);
			else if (!top && b[i])
				h = 6'(i + 1);
		end
		height = h;
	endfunction : height

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_q;
	logic [9:0]        gap_min_q;
	logic [4:0]        gap_max_q;
	logic [9:0]        hold_q;
	logic [15:0]       timeout_q;
	logic [9:0]        deact_q;
	logic [9:0]        act_q;
	logic [11:0]       teach_q;
	logic [2:0]        tol_q;
	logic [8:0]        ovr_tmo_q;
	logic [EV_W-1:0]   irq_stat_q;
	logic [EV_W-1:0]   irq_mask_q;
	logic [15:0]       wv;

	assign wv = wr_data_i[15:0];

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_q     <= RST_CTRL;
			gap_min_q  <= RST_GAP_MIN;
			gap_max_q  <= RST_GAP_MAX;
			hold_q     <= 10'h0;
			timeout_q  <= RST_TIMEOUT;
			deact_q    <= 10'h0;
			act_q      <= 10'h0;
			teach_q    <= RST_TEACH;
			tol_q      <= 3'h0;
			ovr_tmo_q  <= RST_OVR_TMO;
			irq_mask_q <= '0;
		end
		else if (wr_en_i)
		begin
			case (addr_i)
				OFS_CTRL:     ctrl_q <= wr_data_i[CTRL_W-1:0];
				OFS_GAP_MIN:  gap_min_q <= 10'(clamp(wv, 16'(GAP_MIN_LO),
					16'(MS_HI)));
				OFS_GAP_MAX:  gap_max_q <= 5'(clamp(wv, 16'(GAP_MAX_LO),
					16'(GAP_MAX_HI)));
				OFS_HOLD:     hold_q <= 10'(clamp(wv, 16'h0,
					16'(MS_HI)));
				OFS_TIMEOUT:  timeout_q <= clamp(wv, TMO_LO, TMO_HI);
				OFS_DEACT:    deact_q <= 10'(clamp(wv, 16'h0,
					16'(MS_HI)));
				OFS_ACT:      act_q <= 10'(clamp(wv, 16'h0,
					16'(MS_HI)));
				OFS_TEACH:    teach_q <= 12'(clamp(wv, 16'(TEACH_LO),
					16'(TEACH_HI)));
				OFS_BEAM_TOL: tol_q <= 3'(clamp(wv, 16'h0,
					16'(TOL_HI)));
				OFS_OVR_TMO:  ovr_tmo_q <= 9'(clamp(wv, 16'(OVR_LO),
					16'(OVR_HI)));
				OFS_IRQ_MASK: irq_mask_q <= wr_data_i[EV_W-1:0];
				default:      ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// time base and input filters
	// ------------------------------------------------------------
	logic tick;
	logic in_a;
	logic in_b;

	ms_tick #(.DIV(MS_DIV)) u_tick (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.tick_o     (tick)
	);

	mute_filter u_filt_a (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.tick_i     (tick),
		.raw_i      (mute_input_a_i),
		.act_ms_i   (act_q),
		.deact_ms_i (deact_q),
		.level_o    (in_a)
	);

	mute_filter u_filt_b (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.tick_i     (tick),
		.raw_i      (mute_input_b_i),
		.act_ms_i   (act_q),
		.deact_ms_i (deact_q),
		.level_o    (in_b)
	);

	// ------------------------------------------------------------
	// sequence state
	// ------------------------------------------------------------
	mute_state_t state_q;
	mute_state_t state_d;
	logic [25:0] tmr_q;
	logic [25:0] dur_q;
	logic [5:0]  taught_q;
	logic        ovr_prev_q;
	logic [EV_W-1:0] ev;
	logic        ovr_rise;
	logic        lamp_bad;
	logic        gap_over;
	logic        dur_over;
	logic        ovr_over;
	logic        too_tall;
	logic        teach_done;
	logic [5:0]  cur_h;

	assign ovr_rise   = override_i && !ovr_prev_q;
	assign lamp_bad   = ctrl_q[CTRL_LAMP] && !lamp_ok_i;
	assign gap_over   = tmr_q >= 26'(gap_max_q) * 26'(MS_PER_S);
	assign dur_over   = !ctrl_q[CTRL_INFINITE]
		&& dur_q >= 26'(timeout_q) * 26'(MS_PER_S);
	assign ovr_over   = dur_q >= 26'(ovr_tmo_q) * 26'(MS_PER_MIN);
	assign teach_done = dur_q >= 26'(teach_q);
	assign cur_h      = height(beams_i, ctrl_q[CTRL_TOP]);
	assign too_tall   = ctrl_q[CTRL_DYN] && teach_done
		&& cur_h > taught_q + 6'(tol_q);

	always_comb
	begin
		state_d = state_q;
		ev      = '0;
		case (state_q)
			ST_IDLE:
			begin
				if (ovr_rise)
					state_d = ST_OVR;
				else if (curtain_on_i && (in_a || in_b))
					state_d = ST_GAP;
			end
			ST_GAP:
			begin
				if (!in_a && !in_b)
					state_d = ST_IDLE;
				else if (gap_over)
				begin
					state_d     = ST_BLOCK;
					ev[EV_GAP]  = 1'b1;
				end
				else if (in_a && in_b)
				begin
					if (tmr_q < 26'(gap_min_q))
					begin
						state_d    = ST_BLOCK;
						ev[EV_GAP] = 1'b1;
					end
					else if (lamp_bad)
					begin
						state_d     = ST_BLOCK;
						ev[EV_LAMP] = 1'b1;
					end
					else if (curtain_on_i)
					begin
						state_d      = ST_MUTE;
						ev[EV_START] = 1'b1;
					end
				end
			end
			ST_MUTE:
			begin
				if (dur_over)
				begin
					state_d        = ST_BLOCK;
					ev[EV_TIMEOUT] = 1'b1;
				end
				else if (lamp_bad)
				begin
					state_d     = ST_BLOCK;
					ev[EV_LAMP] = 1'b1;
				end
				else if (too_tall)
				begin
					state_d       = ST_BLOCK;
					ev[EV_HEIGHT] = 1'b1;
				end
				else if (!in_a || !in_b)
				begin
					state_d = (hold_q == 10'h0) ? ST_IDLE : ST_HOLD;
					ev[EV_END] = (hold_q == 10'h0);
				end
			end
			ST_HOLD:
			begin
				if (tmr_q >= 26'(hold_q) || dur_over)
				begin
					state_d    = ST_IDLE;
					ev[EV_END] = 1'b1;
				end
			end
			ST_BLOCK:
			begin
				if (ovr_rise)
					state_d = ST_OVR;
				else if (!in_a && !in_b)
					state_d = ST_IDLE;
			end
			ST_OVR:
			begin
				if (ovr_over || (!ctrl_q[CTRL_OVR_EDGE] && !override_i))
				begin
					state_d = ctrl_q[CTRL_OVR_MAN] ? ST_LOCK : ST_IDLE;
					ev[EV_OVR_END] = 1'b1;
				end
			end
			ST_LOCK:
			begin
				if (restart_i)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ovr_prev_q <= 1'b0;
		else
			ovr_prev_q <= override_i;
	end

	// gap and hold timer restarts on every state change
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			tmr_q <= 26'h0;
		else if (state_d != state_q)
			tmr_q <= 26'h0;
		else if (tick)
			tmr_q <= tmr_q + 26'h1;
	end

	// muting or override duration, kept across hold
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			dur_q <= 26'h0;
		else if ((state_d == ST_MUTE && state_q != ST_MUTE && state_q != ST_HOLD)
			|| (state_d == ST_OVR && state_q != ST_OVR))
			dur_q <= 26'h0;
		else if (tick)
			dur_q <= dur_q + 26'h1;
	end

	// tallest material seen during the teach window
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			taught_q <= 6'h0;
		else if (state_q != ST_MUTE && state_q != ST_HOLD)
			taught_q <= 6'h0;
		else if (!teach_done && cur_h > taught_q)
			taught_q <= cur_h;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mute_active_o     <= 1'b0;
			override_active_o <= 1'b0;
			interlock_o       <= 1'b0;
			safety_out_o      <= 1'b0;
		end
		else
		begin
			mute_active_o     <= state_d == ST_MUTE || state_d == ST_HOLD;
			override_active_o <= state_d == ST_OVR;
			interlock_o       <= state_d == ST_LOCK;
			safety_out_o      <= state_d != ST_LOCK && (curtain_on_i
				|| state_d == ST_MUTE || state_d == ST_HOLD
				|| state_d == ST_OVR);
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_stat_q <= '0;
		else if (wr_en_i && addr_i == OFS_IRQ_STAT)
			irq_stat_q <= (irq_stat_q & ~wr_data_i[EV_W-1:0]) | ev;
		else
			irq_stat_q <= irq_stat_q | ev;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_stat_q & irq_mask_q);
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_data_o <= 32'h0;
		else if (!rd_en_i)
			rd_data_o <= 32'h0;
		else
		begin
			case (addr_i)
				OFS_CTRL:     rd_data_o <= 32'(ctrl_q);
				OFS_GAP_MIN:  rd_data_o <= 32'(gap_min_q);
				OFS_GAP_MAX:  rd_data_o <= 32'(gap_max_q);
				OFS_HOLD:     rd_data_o <= 32'(hold_q);
				OFS_TIMEOUT:  rd_data_o <= 32'(timeout_q);
				OFS_DEACT:    rd_data_o <= 32'(deact_q);
				OFS_ACT:      rd_data_o <= 32'(act_q);
				OFS_TEACH:    rd_data_o <= 32'(teach_q);
				OFS_BEAM_TOL: rd_data_o <= 32'(tol_q);
				OFS_OVR_TMO:  rd_data_o <= 32'(ovr_tmo_q);
				OFS_STATUS:   rd_data_o <= {18'h0, taught_q, 3'h0,
					in_b, in_a, 3'(state_q)};
				OFS_IRQ_STAT: rd_data_o <= 32'(irq_stat_q);
				OFS_IRQ_MASK: rd_data_o <= 32'(irq_mask_q);
				default:      rd_data_o <= 32'h0;
			endcase
		end
	end
endmodule : t_mute_ctrl
`default_nettype wire

/* File: test/mute_sensors.sv */
// muting sensor pair and override switch beside the controller
// assumes the bench calls its tasks; MS is clock cycles per ms
`default_nettype none
module mute_sensors #(
	parameter int unsigned MS = 10
) (
	input  wire logic core_clk_i,
	output logic      a_o,
	output logic      b_o,
	output logic      ovr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		a_o = 1'b0;
		b_o = 1'b0;
		ovr_o = 1'b0;
	end
	// first sensor, then both after gap_ms
	task pass(input bit b_first, input int gap_ms);
		@(posedge core_clk_i);
		if (b_first)
			b_o <= 1'b1;
		else
			a_o <= 1'b1;
		repeat (gap_ms * MS) @(posedge core_clk_i);
		a_o <= 1'b1;
		b_o <= 1'b1;
	endtask : pass
	task drop(input bit a, input bit b);
		@(posedge core_clk_i);
		if (a)
			a_o <= 1'b0;
		if (b)
			b_o <= 1'b0;
	endtask : drop
	// switch held for cyc cycles, then let go
	task press(input int cyc);
		@(posedge core_clk_i);
		ovr_o <= 1'b1;
		repeat (cyc) @(posedge core_clk_i);
		ovr_o <= 1'b0;
	endtask : press
endmodule : mute_sensors
`default_nettype wire

/* File: test/t_mute_ctrl_chk.sv */
// port-level checks of the muting controller
// assumes one clock domain and a bind onto every controller
`default_nettype none
module t_mute_ctrl_chk #(
	parameter int unsigned MS_DIV = 10
) (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        rd_en_i,
	input wire logic [31:0] rd_data_o,
	input wire logic        mute_input_a_i,
	input wire logic        mute_input_b_i,
	input wire logic        override_i,
	input wire logic        restart_i,
	input wire logic        mute_active_o,
	input wire logic        override_active_o,
	input wire logic        interlock_o,
	input wire logic        safety_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// cycles of muting with an input already gone
	int unsigned tail_q;
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			tail_q <= 0;
		else if (mute_active_o && !(mute_input_a_i && mute_input_b_i))
			tail_q <= tail_q + 1;
		else
			tail_q <= 0;
	end
	// idle muting with at most one input present
	sequence s_unpaired;
		!mute_active_o && !(mute_input_a_i && mute_input_b_i);
	endsequence
	sequence s_lock_hold;
		interlock_o && !restart_i;
	endsequence
	a_mute_both_in: assert property (s_unpaired |=> !mute_active_o)
		else $error("muting began without both inputs");
	a_mute_end_bound: assert property (tail_q <= 2002 * MS_DIV)
		else $error("muting outlived dropped input");
	a_ovr_from_edge: assert property ($rose(override_active_o) |->
		$past(override_i) && !$past(override_i, 2))
		else $error("override without request edge");
	a_lock_holds: assert property (s_lock_hold |=> interlock_o)
		else $error("interlock left without restart");
	a_lock_unsafe: assert property (interlock_o && $past(interlock_o) |->
		!safety_out_o)
		else $error("safety high in interlock");
	a_lock_origin: assert property ($rose(interlock_o) |->
		$past(override_active_o) || $past(override_active_o, 2))
		else $error("interlock not after override");
	a_ovr_safe_high: assert property (override_active_o &&
		$past(override_active_o) |-> safety_out_o)
		else $error("safety low during override");
	a_rd_idle_zero: assert property (!$past(rd_en_i) |-> rd_data_o == 32'h0)
		else $error("read data outside read cycle");
	a_mute_excl_ovr: assert property (!(mute_active_o && override_active_o))
		else $error("muting and override together");
endmodule : t_mute_ctrl_chk
bind t_mute_ctrl t_mute_ctrl_chk #(.MS_DIV(MS_DIV)) u_chk (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
	.mute_input_a_i(mute_input_a_i), .mute_input_b_i(mute_input_b_i),
	.override_i(override_i), .restart_i(restart_i), .mute_active_o(mute_active_o),
	.override_active_o(override_active_o), .interlock_o(interlock_o),
	.safety_out_o(safety_out_o)
);
`default_nettype wire

/* File: test/t_mute_ctrl_test.sv */
// self-checking bench of the two-signal muting controller
// assumes mute_sensors as far side and a 10-cycle millisecond
`default_nettype none
module t_mute_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mute_pkg::*;
	localparam int unsigned MS = 10;
	logic core_clk_i, rst_i, wr_en, rd_en, curtain, lamp_ok, restart;
	logic mute_a, mute_b, ovr, mute_act, ovr_act, lock, safe, irq;
	logic [7:0]  addr;
	logic [15:0] beams;
	logic [31:0] wr_data, rd_data;
	int n_mismatch, n_compared;
	t_mute_ctrl #(.MS_DIV(MS), .BEAMS(16)) dut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wr_data),
		.wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data), .mute_input_a_i(mute_a),
		.mute_input_b_i(mute_b), .curtain_on_i(curtain), .beams_i(beams),
		.lamp_ok_i(lamp_ok), .override_i(ovr), .restart_i(restart),
		.mute_active_o(mute_act), .override_active_o(ovr_act), .interlock_o(lock),
		.safety_out_o(safe), .irq_o(irq)
	);
	mute_sensors #(.MS(MS)) sens (.core_clk_i(core_clk_i), .a_o(mute_a), .b_o(mute_b),
		.ovr_o(ovr));
	// ------------------------------------------------------------
	// bus and check helpers
	// ------------------------------------------------------------
	task chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk_i);
		wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk_i);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk_i);
		rd_en <= 1'b0;
		#1;
		chk(rd_data === e, "register read");
	endtask : rd
	task wait_cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : wait_cyc
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_regs;
		rd(OFS_GAP_MAX, 32'h4);
		rd(OFS_GAP_MIN, 32'h64);
		rd(OFS_HOLD, 32'h0);
		rd(OFS_DEACT, 32'h0);
		rd(OFS_ACT, 32'h0);
		rd(OFS_TIMEOUT, 32'h258);
		rd(OFS_TEACH, 32'h7d0);
		rd(OFS_BEAM_TOL, 32'h0);
		rd(OFS_OVR_TMO, 32'h2);
		wr(OFS_TIMEOUT, 32'h0);
		rd(OFS_TIMEOUT, 32'ha);
		wr(OFS_BEAM_TOL, 32'h7);
		rd(OFS_BEAM_TOL, 32'h6);
		wr(OFS_OVR_TMO, 32'h3ff);
		rd(OFS_OVR_TMO, 32'h100);
		rd(8'hfc, 32'h0);
		wr(OFS_GAP_MAX, 32'h20);
		rd(OFS_GAP_MAX, 32'h10);
		wr(OFS_GAP_MIN, 32'h1);
		rd(OFS_GAP_MIN, 32'ha);
		wr(OFS_HOLD, 32'h7d0);
		rd(OFS_HOLD, 32'h3e8);
		wr(OFS_HOLD, 32'h0);
		wr(OFS_GAP_MAX, 32'h1);
		wr(OFS_IRQ_MASK, 32'h7f);
	endtask : t_regs
	task t_mute(input bit b_first);
		sens.pass(b_first, 20);
		wait_cyc(6);
		chk(mute_act === 1'b1, "muting missing");
		rd(OFS_IRQ_STAT, 32'h1);
		chk(irq === 1'b1, "irq missing");
		wr(OFS_IRQ_STAT, 32'h7f);
		sens.drop(1'b1, 1'b0);
		wait_cyc(6);
		chk(mute_act === 1'b0, "muting stuck");
		rd(OFS_IRQ_STAT, 32'h2);
		sens.drop(1'b0, 1'b1);
		wait_cyc(4);
		wr(OFS_IRQ_STAT, 32'h7f);
	endtask : t_mute
	task t_short;
		wr(OFS_IRQ_MASK, 32'h0);
		sens.pass(1'b0, 5);
		wait_cyc(6);
		chk(mute_act === 1'b0, "short gap muted");
		rd(OFS_IRQ_STAT, 32'h4);
		chk(irq === 1'b0, "masked irq high");
		wr(OFS_IRQ_MASK, 32'h4);
		wait_cyc(3);
		chk(irq === 1'b1, "unmasked irq low");
		wr(OFS_IRQ_STAT, 32'h4);
		wait_cyc(3);
		chk(irq === 1'b0, "cleared irq high");
		sens.drop(1'b1, 1'b1);
		wait_cyc(4);
		wr(OFS_IRQ_MASK, 32'h7f);
	endtask : t_short
	task t_long;
		sens.pass(1'b0, 1020);
		wait_cyc(6);
		chk(mute_act === 1'b0, "long gap muted");
		rd(OFS_IRQ_STAT, 32'h4);
		sens.drop(1'b1, 1'b1);
		wait_cyc(4);
		wr(OFS_IRQ_STAT, 32'h7f);
	endtask : t_long
	task t_hold;
		wr(OFS_HOLD, 32'h5);
		sens.pass(1'b1, 20);
		wait_cyc(6);
		sens.drop(1'b1, 1'b0);
		wait_cyc(20);
		chk(mute_act === 1'b1, "hold cut short");
		wait_cyc(60);
		chk(mute_act === 1'b0, "hold too long");
		sens.drop(1'b0, 1'b1);
		wr(OFS_HOLD, 32'h0);
		wr(OFS_IRQ_STAT, 32'h7f);
	endtask : t_hold
	task t_curtain;
		@(posedge core_clk_i);
		curtain <= 1'b0;
		sens.pass(1'b0, 20);
		wait_cyc(6);
		chk(mute_act === 1'b0, "muted with curtain off");
		sens.drop(1'b1, 1'b1);
		wait_cyc(4);
		curtain <= 1'b1;
		wr(OFS_IRQ_STAT, 32'h7f);
	endtask : t_curtain
	task t_lamp;
		wr(OFS_CTRL, 32'h4);
		lamp_ok <= 1'b0;
		sens.pass(1'b0, 20);
		wait_cyc(6);
		chk(mute_act === 1'b0, "muted without lamp");
		rd(OFS_IRQ_STAT, 32'h10);
		sens.drop(1'b1, 1'b1);
		wait_cyc(4);
		lamp_ok <= 1'b1;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_STAT, 32'h7f);
	endtask : t_lamp
	// dynamic muting from top: taught height 3, tolerance 2
	task t_dyn;
		wr(OFS_CTRL, 32'h3);
		wr(OFS_TEACH, 32'h0);
		wr(OFS_BEAM_TOL, 32'h2);
		beams <= 16'he000;
		rd(OFS_TEACH, 32'h1f4);
		sens.pass(1'b0, 20);
		wait_cyc(5200);
		rd(OFS_STATUS, 32'h31a);
		@(posedge core_clk_i);
		beams <= 16'hf800;
		wait_cyc(4);
		chk(mute_act === 1'b1, "tolerated beams cut muting");
		beams <= 16'hfc00;
		wait_cyc(4);
		chk(mute_act === 1'b0, "muting above taught height");
		rd(OFS_IRQ_STAT, 32'h21);
		sens.drop(1'b1, 1'b1);
		beams <= 16'h0;
		wait_cyc(4);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_STAT, 32'h7f);
	endtask : t_dyn
	task t_ovr_level(input bit man);
		wr(OFS_CTRL, man ? 32'h10 : 32'h0);
		sens.press(30);
		wait_cyc(5);
		chk(ovr_act === 1'b0, "override outlived release");
		rd(OFS_IRQ_STAT, 32'h40);
		chk(lock === man, "interlock state");
		chk(safe === !man, "safety after override");
		if (man)
		begin
			@(posedge core_clk_i);
			restart <= 1'b1;
			wait_cyc(3);
			restart <= 1'b0;
			wait_cyc(3);
			chk(lock === 1'b0, "interlock kept");
			chk(safe === 1'b1, "safety not back");
		end
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_STAT, 32'h7f);
	endtask : t_ovr_level
	task t_ovr_edge;
		wr(OFS_CTRL, 32'h8);
		sens.press(1);
		wait_cyc(50);
		chk(ovr_act === 1'b1, "edge override ended");
		rst_i <= 1'b1;
		wait_cyc(2);
		rst_i <= 1'b0;
		wait_cyc(2);
		chk(ovr_act === 1'b0, "override through reset");
		rd(OFS_CTRL, 32'h0);
	endtask : t_ovr_edge
	// ------------------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	initial
	begin
		#400_000;
		n_mismatch++;
		print_verdict;
	end
	initial
	begin
		{wr_en, rd_en, restart, addr, wr_data, beams} = '0;
		curtain = 1'b1;
		lamp_ok = 1'b1;
		rst_i = 1'b1;
		n_mismatch = 0;
		n_compared = 0;
		wait_cyc(8);
		rst_i <= 1'b0;
		t_regs;
		t_mute(1'b0);
		t_mute(1'b1);
		t_short;
		t_long;
		t_hold;
		t_curtain;
		t_lamp;
		t_dyn;
		t_ovr_level(1'b1);
		t_ovr_level(1'b0);
		t_ovr_edge;
		print_verdict;
	end
endmodule : t_mute_ctrl_test
`default_nettype wire
